// ==== logic/pwmcp_pkg.sv ====
package pwmcp_pkg;

  // ----------------------------------------------------------------
  // basic types
  // ----------------------------------------------------------------
  typedef logic [7:0]  pwmcp_byte_t;   // one register byte
  typedef logic [15:0] pwmcp_word_t;   // paired channel value

  // pin bundle toward the shared port pins
  typedef struct packed {
    logic [3:0] out;                   // level driven onto each pin
    logic [3:0] oe;                    // high while the pin is driven
  } pwmcp_pins_s;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the plain port)
  // ----------------------------------------------------------------
  localparam pwmcp_byte_t OFF_CLK_PAIR = 8'h40;  // prescale and pairing
  localparam pwmcp_byte_t OFF_SEL_POL  = 8'h41;  // clock select, polarity
  localparam pwmcp_byte_t OFF_ENABLE   = 8'h42;  // channel enables
  localparam pwmcp_byte_t OFF_PRESCNT  = 8'h43;  // prescale counter, read only
  localparam pwmcp_byte_t OFF_SCALE0   = 8'h44;  // first scale value
  localparam pwmcp_byte_t OFF_SCNT0    = 8'h45;  // first scale counter
  localparam pwmcp_byte_t OFF_SCALE1   = 8'h46;  // second scale value
  localparam pwmcp_byte_t OFF_SCNT1    = 8'h47;  // second scale counter
  localparam pwmcp_byte_t OFF_CNT0     = 8'h48;  // channel counters 0..3
  localparam pwmcp_byte_t OFF_PER0     = 8'h4c;  // channel periods 0..3
  localparam pwmcp_byte_t OFF_DTY0     = 8'h50;  // channel duties 0..3
  localparam pwmcp_byte_t OFF_CENTER   = 8'h54;  // center-align selects

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PAIR23_BIT = 7;      // pair channels two and three
  localparam int PAIR01_BIT = 6;      // pair channels zero and one
  localparam int PRE_A_LSB  = 3;      // prescale a select, 3 bits
  localparam int PRE_B_LSB  = 0;      // prescale b select, 3 bits
  localparam int CSEL_LSB   = 4;      // scaled clock selects, ch3..ch0
  localparam int POL_LSB    = 0;      // high-first bits, ch3..ch0
  localparam int PRE_W      = 3;      // prescale select width

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam pwmcp_byte_t RST_CTL    = 8'h00;  // controls, enables, scales
  localparam pwmcp_byte_t RST_PERDTY = 8'hff;  // period and duty
  localparam logic [6:0]  RST_PRES   = 7'h00;  // prescale counter
  localparam logic [6:0]  PRES_FULL  = 7'h7f;  // all prescale bits set

endpackage

// ==== logic/pwmcp_scaler.sv ====
`timescale 1ns/10ps
`default_nettype none

// divides a prescaled tick by (scale+1) and again by two
module pwmcp_scaler
  import pwmcp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // prescaled tick and scale setting
  input  wire logic        tick_i,
  input  wire pwmcp_byte_t scale_i,
  input  wire logic        load_i,
  input  wire pwmcp_byte_t load_val_i,
  // scaled tick and counter readback
  output logic             tick_o,
  output pwmcp_byte_t      count_o
);

  logic half_r;  // second divide-by-two stage

  // ----------------------------------------------------------------
  // down counter, reloads at zero
  // ----------------------------------------------------------------
  // a scale write reloads at once so a new rate starts cleanly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_o <= RST_CTL;
      half_r  <= 1'b0;
    end
    else if (load_i)
    begin
      count_o <= load_val_i;
    end
    else if (tick_i)
    begin
      if (count_o == 8'h00)
      begin
        // zero reached: reload, which gives scale+1 ticks per turn
        count_o <= scale_i;
        half_r  <= ~half_r;
      end
      else
      begin
        count_o <= count_o - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // output pulse, one every second reload
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= tick_i && !load_i && (count_o == 8'h00) && half_r;
    end
  end

endmodule

`default_nettype wire

// ==== logic/pwmcp_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module pwmcp_top
  import pwmcp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire pwmcp_byte_t addr_i,
  input  wire pwmcp_byte_t wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output pwmcp_byte_t      rd_data_o,
  // general-purpose port logic sharing the pins
  input  wire logic [3:0]  gpio_out_i,
  input  wire logic [3:0]  gpio_oe_i,
  // shared port pins
  output pwmcp_pins_s      pin_o
);

  // all checks sample on the one clock and sleep through reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic        pair_ch_two_three;       // channels two and three joined
  logic        pair_ch_zero_one;        // channels zero and one joined
  logic [2:0]  prescale_a_sel;          // clock a = base / 2**sel
  logic [2:0]  prescale_b_sel;          // clock b = base / 2**sel
  logic [3:0]  scaled_clk_sel_r;        // per channel: scaled clock
  logic [3:0]  high_first_r;            // per channel: start high, left-aligned mode only
  logic [3:0]  channel_enable_bits;     // per channel enable
  logic [3:0]  center_align_sel;        // per channel center mode
  pwmcp_byte_t scale_value_first;       // first scale value
  pwmcp_byte_t scale_value_second;      // second scale value
  logic [6:0]  pres_r;                  // prescale count, runs while any channel is enabled

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  pwmcp_byte_t channel_counter [4];     // live counters
  pwmcp_byte_t per_buf_r [4];           // period as last written
  pwmcp_byte_t per_act_r [4];           // period in use
  pwmcp_byte_t dty_buf_r [4];           // duty as last written
  pwmcp_byte_t dty_act_r [4];           // duty in use
  logic [3:0]  down_r;                  // center mode counting down

  // ----------------------------------------------------------------
  // derived signals
  // ----------------------------------------------------------------
  logic [1:0]  pair_v;                  // pairing per channel pair
  logic [1:0]  p_tick;                  // prescaled ticks a, b
  logic [1:0]  s_tick;                  // scaled ticks first, second
  pwmcp_byte_t scnt [2];                // scale counters
  logic [6:0]  mask_a;                  // prescale a compare mask
  logic [6:0]  mask_b;                  // prescale b compare mask
  pwmcp_word_t u_cnt [4];               // unit count, 8 or 16 bits
  pwmcp_word_t u_per [4];               // unit period in use
  pwmcp_word_t u_dty [4];               // unit duty in use
  pwmcp_word_t nxt_cnt [4];             // unit count after a tick
  logic [3:0]  nxt_down;                // direction after a tick
  logic [3:0]  end_hit;                 // period end reached
  logic [3:0]  wide;                    // unit is a 16-bit pair
  logic [3:0]  u_tick;                  // unit's selected clock
  logic [3:0]  u_live;                  // unit counts and owns its pin
  logic [3:0]  run_eff;                 // channel counts as running
  logic [3:0]  cnt_clr;                 // counter write hits channel
  logic [3:0]  roll;                    // unit ends a period this cycle
  logic [3:0]  latch;                   // copy buffers to active
  logic [3:0]  wave;                    // waveform level
  logic        any_en;                  // some channel enabled
  pwmcp_byte_t rd_val;                  // read mux result

  assign pair_v = {pair_ch_two_three, pair_ch_zero_one};
  assign any_en = |channel_enable_bits;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // stops with every channel off, saving toggling power
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pres_r <= RST_PRES;
    end
    else if (any_en)
    begin
      pres_r <= pres_r + 7'h01;
    end
  end

  // tick when the low sel bits are all ones: divide by 2**sel
  assign mask_a    = PRES_FULL >> (3'd7 - prescale_a_sel);
  assign mask_b    = PRES_FULL >> (3'd7 - prescale_b_sel);
  assign p_tick[0] = any_en && ((pres_r & mask_a) == mask_a);
  assign p_tick[1] = any_en && ((pres_r & mask_b) == mask_b);

  // ----------------------------------------------------------------
  // scaled clocks
  // ----------------------------------------------------------------
  pwmcp_scaler u_scale_first (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (p_tick[0]),
    .scale_i    (scale_value_first),
    .load_i     (wr_i && addr_i == OFF_SCALE0),
    .load_val_i (wr_data_i),
    .tick_o     (s_tick[0]),
    .count_o    (scnt[0])
  );

  pwmcp_scaler u_scale_second (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .tick_i     (p_tick[1]),
    .scale_i    (scale_value_second),
    .load_i     (wr_i && addr_i == OFF_SCALE1),
    .load_val_i (wr_data_i),
    .tick_o     (s_tick[1]),
    .count_o    (scnt[1])
  );

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pair_ch_two_three   <= 1'b0;
      pair_ch_zero_one    <= 1'b0;
      prescale_a_sel      <= 3'h0;
      prescale_b_sel      <= 3'h0;
      scaled_clk_sel_r    <= 4'h0;
      high_first_r        <= 4'h0;
      channel_enable_bits <= 4'h0;
      center_align_sel    <= 4'h0;
      scale_value_first   <= RST_CTL;
      scale_value_second  <= RST_CTL;
    end
    else if (wr_i)
    begin
      case (addr_i)
        OFF_CLK_PAIR:
        begin
          pair_ch_two_three <= wr_data_i[PAIR23_BIT];
          pair_ch_zero_one  <= wr_data_i[PAIR01_BIT];
          prescale_a_sel    <= wr_data_i[PRE_A_LSB +: PRE_W];
          prescale_b_sel    <= wr_data_i[PRE_B_LSB +: PRE_W];
        end
        OFF_SEL_POL:
        begin
          // a change while running may clip one pulse, software's care
          scaled_clk_sel_r <= wr_data_i[CSEL_LSB +: 4];
          high_first_r     <= wr_data_i[POL_LSB +: 4];
        end
        OFF_ENABLE: channel_enable_bits <= wr_data_i[3:0];
        OFF_SCALE0: scale_value_first   <= wr_data_i;
        OFF_SCALE1: scale_value_second  <= wr_data_i;
        OFF_CENTER: center_align_sel    <= wr_data_i[3:0];
        default:    ;  // data registers handled below
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-unit datapath
  // ----------------------------------------------------------------
  // unit c is channel c; a paired high channel runs 16 bits wide
  for (genvar c = 0; c < 4; c++)
  begin : g_unit
    localparam int  HI    = (c / 2) * 2;        // high byte channel
    localparam int  LO    = HI + 1;             // low byte channel
    localparam int  P     = c / 2;              // channel pair
    localparam bit  IS_HI = (c % 2) == 0;       // high position
    localparam pwmcp_byte_t A_CNT  = pwmcp_byte_t'(OFF_CNT0 + c);
    localparam pwmcp_byte_t A_MATE = pwmcp_byte_t'(OFF_CNT0 + (c ^ 1));

    assign wide[c]  = IS_HI && pair_v[P];
    assign u_cnt[c] = wide[c] ? {channel_counter[c], channel_counter[LO]}
                              : {8'h00, channel_counter[c]};
    assign u_per[c] = wide[c] ? {per_act_r[c], per_act_r[LO]}
                              : {8'h00, per_act_r[c]};
    assign u_dty[c] = wide[c] ? {dty_act_r[c], dty_act_r[LO]}
                              : {8'h00, dty_act_r[c]};

    // the low channel's select drives a pair
    assign u_tick[c] = (wide[c] ? scaled_clk_sel_r[LO] : scaled_clk_sel_r[c])
                       ? s_tick[P] : p_tick[P];

    // a paired low channel idles and frees its pin
    assign u_live[c]  = channel_enable_bits[c] && !(pair_v[P] && !IS_HI);
    assign run_eff[c] = pair_v[P] ? channel_enable_bits[HI]
                                  : channel_enable_bits[c];

    // writing either half of a pair restarts the whole pair
    assign cnt_clr[c] = wr_i && (addr_i == A_CNT || (pair_v[P] && addr_i == A_MATE));

    // next count and direction
    always_comb
    begin
      nxt_cnt[c]  = u_cnt[c] + 16'h0001;
      nxt_down[c] = down_r[c];
      end_hit[c]  = 1'b0;
      if (!center_align_sel[c])
      begin
        // left: 0..per then wrap, per+1 clocks
        if (u_cnt[c] >= u_per[c])
        begin
          nxt_cnt[c] = 16'h0000;
          end_hit[c] = 1'b1;
        end
      end
      else if (!down_r[c])
      begin
        // center, rising: turn at the period match
        if (u_cnt[c] >= u_per[c])
        begin
          nxt_down[c] = 1'b1;
          nxt_cnt[c]  = (u_cnt[c] == 16'h0000) ? 16'h0000 : u_cnt[c] - 16'h0001;
        end
      end
      else if (u_cnt[c] == 16'h0000)
      begin
        // center, falling: zero starts a new 2*per period
        nxt_down[c] = 1'b0;
        end_hit[c]  = 1'b1;
        nxt_cnt[c]  = (u_per[c] == 16'h0000) ? 16'h0000 : 16'h0001;
      end
      else
      begin
        nxt_cnt[c] = u_cnt[c] - 16'h0001;
      end
    end

    assign roll[c]  = u_live[c] && u_tick[c] && end_hit[c];
    assign latch[c] = !run_eff[c] || cnt_clr[c] || (pair_v[P] ? roll[HI] : roll[c]);

    // duty 0 keeps the low-first wave high all period, above per low
    assign wave[c] = (center_align_sel[c] || !high_first_r[c])
                     ? (u_cnt[c] >= u_dty[c])
                     : (u_cnt[c] <  u_dty[c]);
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // counters keep their value across disable; software clears them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < 4; c++)
      begin
        channel_counter[c] <= RST_CTL;
      end
      down_r <= 4'h0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (cnt_clr[c])
        begin
          channel_counter[c] <= RST_CTL;
          down_r[c]          <= 1'b0;
        end
        else if (u_live[c] && u_tick[c])
        begin
          if (wide[c])
          begin
            channel_counter[c]     <= nxt_cnt[c][15:8];
            channel_counter[c | 1] <= nxt_cnt[c][7:0];
          end
          else
          begin
            channel_counter[c] <= nxt_cnt[c][7:0];
          end
          down_r[c] <= nxt_down[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // period and duty double buffers
  // ----------------------------------------------------------------
  // latching the value being written avoids losing a same-cycle write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < 4; c++)
      begin
        per_buf_r[c] <= RST_PERDTY;
        per_act_r[c] <= RST_PERDTY;
        dty_buf_r[c] <= RST_PERDTY;
        dty_act_r[c] <= RST_PERDTY;
      end
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (wr_i && addr_i == pwmcp_byte_t'(OFF_PER0 + c))
        begin
          per_buf_r[c] <= wr_data_i;
          if (latch[c])
          begin
            per_act_r[c] <= wr_data_i;
          end
        end
        else if (latch[c])
        begin
          per_act_r[c] <= per_buf_r[c];
        end
        if (wr_i && addr_i == pwmcp_byte_t'(OFF_DTY0 + c))
        begin
          dty_buf_r[c] <= wr_data_i;
          if (latch[c])
          begin
            dty_act_r[c] <= wr_data_i;
          end
        end
        else if (latch[c])
        begin
          dty_act_r[c] <= dty_buf_r[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin sharing
  // ----------------------------------------------------------------
  // a live channel overrides the port's level and direction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= '0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        pin_o.out[c] <= u_live[c] ? wave[c] : gpio_out_i[c];
        pin_o.oe[c]  <= u_live[c] || gpio_oe_i[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = 8'h00;  // unmapped offsets read zero
    case (addr_i)
      OFF_CLK_PAIR: rd_val = {pair_ch_two_three, pair_ch_zero_one,
                              prescale_a_sel, prescale_b_sel};
      OFF_SEL_POL:  rd_val = {scaled_clk_sel_r, high_first_r};
      OFF_ENABLE:   rd_val = {4'h0, channel_enable_bits};
      OFF_PRESCNT:  rd_val = {1'b0, pres_r};
      OFF_SCALE0:   rd_val = scale_value_first;
      OFF_SCNT0:    rd_val = scnt[0];
      OFF_SCALE1:   rd_val = scale_value_second;
      OFF_SCNT1:    rd_val = scnt[1];
      OFF_CENTER:   rd_val = {4'h0, center_align_sel};
      default:
      begin
        for (int c = 0; c < 4; c++)
        begin
          if (addr_i == pwmcp_byte_t'(OFF_CNT0 + c)) rd_val = channel_counter[c];
          if (addr_i == pwmcp_byte_t'(OFF_PER0 + c)) rd_val = per_buf_r[c];
          if (addr_i == pwmcp_byte_t'(OFF_DTY0 + c)) rd_val = dty_buf_r[c];
        end
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= RST_CTL;
    end
    else
    begin
      rd_data_o <= rd_i ? rd_val : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_div8_arm;
    (p_tick[0] && prescale_a_sel == 3'd3 && any_en) ##1
    (prescale_a_sel == 3'd3 && any_en && !wr_i && !p_tick[0])[*7];
  endsequence

  a_prescale_div8: assert property (s_div8_arm |=> p_tick[0])
    else $error("prescale a at sel 3 did not tick every 8 cycles");

  a_cnt_write_clear: assert property (
    (wr_i && addr_i == OFF_CNT0) |=> channel_counter[0] == 8'h00)
    else $error("counter write did not clear channel zero");

  a_period_held: assert property (
    (wr_i && addr_i == OFF_PER0 && run_eff[0] && !roll[0] && !cnt_clr[0])
    |=> per_act_r[0] == $past(per_act_r[0]))
    else $error("running period changed before rollover");

  a_period_direct: assert property (
    (wr_i && addr_i == OFF_PER0 && !run_eff[0])
    |=> per_act_r[0] == $past(wr_data_i))
    else $error("idle period write did not reach active latch");

  a_left_wrap: assert property (
    (u_live[0] && u_tick[0] && !center_align_sel[0] && !pair_ch_zero_one
     && !cnt_clr[0] && !cnt_clr[1] && u_cnt[0] == u_per[0])
    |=> channel_counter[0] == 8'h00)
    else $error("left counter did not wrap at period match");

  a_center_turn: assert property (
    (u_live[2] && u_tick[2] && center_align_sel[2] && !down_r[2] && !cnt_clr[2]
     && !pair_ch_two_three && u_cnt[2] == u_per[2] && u_per[2] != 16'h0000)
    |=> down_r[2] ##0 channel_counter[2] == $past(channel_counter[2]) - 8'h01)
    else $error("center counter did not turn down at period match");

  a_left_polarity: assert property (
    (u_live[1] && !center_align_sel[1] && high_first_r[1] && u_cnt[1] < u_dty[1])
    |=> pin_o.out[1] && pin_o.oe[1])
    else $error("high-first channel not high before duty match");

  a_pair_pin_free: assert property (
    (pair_ch_zero_one && !gpio_oe_i[1]) |=> !pin_o.oe[1])
    else $error("paired low channel still drives its pin");

  a_pin_override: assert property (
    (channel_enable_bits[2] && !pair_ch_two_three) |=> pin_o.oe[2])
    else $error("enabled channel did not take its pin");

endmodule

`default_nettype wire

// ==== verification/pwmcp_load.sv ====
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------
// loads on the shared port pins
// --------------------------------------------------------------
// an undriven pin is pulled up, so a lost enable shows as high
module pwmcp_load
  import pwmcp_pkg::*;
(
  // pins from the block
  input  wire pwmcp_pins_s pin_i,
  // resolved wire level per pin
  output logic [3:0]       level_o
);
  assign level_o = (pin_i.oe & pin_i.out) | ~pin_i.oe;
endmodule

`default_nettype wire

// ==== verification/pwmcp_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module pwmcp_tb_top
  import pwmcp_pkg::*;
;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wr_i  = 1'b0;
  logic        rd_i  = 1'b0;
  pwmcp_byte_t addr_i    = 8'h00;
  pwmcp_byte_t wr_data_i = 8'h00;
  pwmcp_byte_t rd_data_o;
  logic [3:0]  gpio_out_i = 4'h0;
  logic [3:0]  gpio_oe_i  = 4'h0;
  logic [3:0]  level;
  pwmcp_pins_s pin_o;
  int          error_cnt = 0;
  int          compares  = 0;

  always #4 clk_i = ~clk_i;

  pwmcp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_o(pin_o));
  pwmcp_load LOAD (.pin_i(pin_o), .level_o(level));

  // one comparison, counted
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // register port cycles
  task automatic wr(pwmcp_byte_t a, pwmcp_byte_t d);
    @(posedge clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(pwmcp_byte_t a, output pwmcp_byte_t d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  // control reset values, read back, unmapped place
  task automatic t_regs;
    pwmcp_byte_t d;
    rd(OFF_CLK_PAIR, d);
    chk("clk_pair rst", 8'h00, d);
    rd(OFF_SEL_POL, d);
    chk("sel_pol rst", 8'h00, d);
    wr(OFF_CLK_PAIR, 8'hed);
    rd(OFF_CLK_PAIR, d);
    chk("clk_pair", 8'hed, d);
    wr(OFF_SEL_POL, 8'h5a);
    rd(OFF_SEL_POL, d);
    chk("sel_pol", 8'h5a, d);
    // read data must fall back to zero one cycle later
    @(posedge clk_i);
    #1 chk("rd_data idle", 8'h00, rd_data_o);
    rd(8'h60, d);
    chk("unmapped", 8'h00, d);
    wr(OFF_CLK_PAIR, 8'h00);
    wr(OFF_SEL_POL, 8'h00);
  endtask

  // idle channels leave the pins to the port logic
  task automatic t_gpio;
    @(posedge clk_i);
    gpio_out_i <= 4'h5;
    gpio_oe_i  <= 4'hf;
    repeat (2) @(posedge clk_i);
    #1 chk("pin out", 8'h05, {4'h0, pin_o.out});
    chk("pin oe", 8'h0f, {4'h0, pin_o.oe});
    @(posedge clk_i);
    gpio_out_i <= 4'h0;
    gpio_oe_i  <= 4'h0;
  endtask

  // channel 0 high cycles over a whole number of periods
  task automatic t_wave(logic pol, logic cen, int exp, int win);
    logic [7:0] n;
    n = 8'h00;
    wr(OFF_SEL_POL, {7'h00, pol});
    wr(OFF_CENTER, {7'h00, cen});
    wr(OFF_PER0, 8'h03);
    wr(OFF_DTY0, 8'h01);
    wr(OFF_ENABLE, 8'h01);
    wr(OFF_CNT0, 8'h00);
    repeat (4) @(posedge clk_i);
    repeat (win)
    begin
      @(posedge clk_i);
      #1 n = n + {7'h00, level[0]};
    end
    chk("ch0 high", exp[7:0], n);
    wr(OFF_ENABLE, 8'h00);
  endtask

  // pair zero/one beside a centred channel two, then prescale a at /8
  task automatic t_pair;
    pwmcp_byte_t d;
    pwmcp_byte_t e;
    wr(OFF_PER0 + 8'h02, 8'h03);
    wr(OFF_CENTER, 8'h04);
    wr(OFF_CLK_PAIR, 8'h40);
    wr(OFF_ENABLE, 8'h05);
    wr(OFF_CNT0, 8'h00);
    rd(OFF_CNT0 + 8'h01, d);
    chk("pair low byte", 8'h01, d);
    rd(OFF_CNT0, d);
    chk("pair high byte", 8'h00, d);
    chk("pair pin oe", 8'h05, {4'h0, pin_o.oe});
    wr(OFF_PER0, 8'h02);
    rd(OFF_PER0, d);
    chk("period buffer", 8'h02, d);
    wr(OFF_CLK_PAIR, 8'h58);
    rd(OFF_CNT0 + 8'h01, d);
    repeat (14) @(posedge clk_i);
    rd(OFF_CNT0 + 8'h01, e);
    chk("prescale a steps", d + 8'h02, e);
    wr(OFF_ENABLE, 8'h00);
  endtask

  // channel one alone high first, then pair two/three on scaled clock
  task automatic t_solo;
    pwmcp_byte_t d;
    pwmcp_byte_t e;
    wr(OFF_CLK_PAIR, 8'h00);
    wr(OFF_SEL_POL, 8'h02);
    wr(OFF_CNT0 + 8'h01, 8'h00);
    wr(OFF_ENABLE, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk("ch1 high first", 8'h01, {7'h00, level[1]});
    wr(OFF_ENABLE, 8'h00);
    wr(OFF_CENTER, 8'h00);
    wr(OFF_PER0 + 8'h02, 8'hff);
    wr(OFF_CLK_PAIR, 8'h81);
    wr(OFF_SEL_POL, 8'h80);
    wr(OFF_CNT0 + 8'h02, 8'h00);
    wr(OFF_ENABLE, 8'h04);
    rd(OFF_CNT0 + 8'h03, d);
    repeat (14) @(posedge clk_i);
    rd(OFF_CNT0 + 8'h03, e);
    chk("scaled b steps", d + 8'h04, e);
    wr(OFF_ENABLE, 8'h00);
  endtask

  // verdict
  task automatic results;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    error_cnt++;
    results;
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_gpio;
    t_wave(1'b0, 1'b0, 6, 8);
    t_wave(1'b1, 1'b0, 2, 8);
    t_wave(1'b0, 1'b1, 10, 12);
    t_pair;
    t_solo;
    results;
  end
endmodule

`default_nettype wire
